// file: hdl/flash_cfg_protect.sv
// Read configuration, boot register and write protection of a serial flash
`timescale 1ns/1ps
`default_nettype none
module flash_cfg_protect (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic ce_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic qpi_mode_i,
  input wire logic [3:0] read_dummy_setting_i,
  output logic so_o,
  output logic so_oe_o,
  output logic [flash_cfg_pkg::DS_W-1:0] drive_strength_o,
  output logic [3:0] dummy_cycles_o,
  output logic read_cmd_valid_o,
  output logic [23:0] boot_start_address_o,
  output logic [3:0] boot_delay_cycles_o,
  output logic boot_enable_o,
  output logic boot_data_start_o,
  output logic quad_enable_o,
  output logic status_write_disable_o,
  output logic [3:0] block_protect_o,
  output logic write_enable_latch_o,
  output logic pe_start_o,
  output logic pe_refused_o,
  output logic [23:0] pe_address_o
);
  import flash_cfg_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_OPCODE, PH_BODY, PH_BOOT} phase_t;

  logic [3:0] pins_s;
  logic sck_s;
  logic ce_n_s;
  logic si_s;
  logic wp_n_s;
  logic sck_d;
  logic ce_n_d;
  logic sck_rise;
  logic sck_fall;
  logic ce_fall;
  logic ce_rise;
  phase_t phase;
  logic [5:0] bit_cnt;
  logic [31:0] in_sr;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  logic [23:0] addr_q;
  logic [31:0] out_sr;
  logic out_act;
  logic [2:0] ext_persist;
  logic load_pending;
  logic [18:0] boot_addr;
  logic [3:0] boot_dly;
  logic boot_armed;
  logic [3:0] boot_cnt;
  logic exec;
  logic sr_locked;
  logic is_pe;
  logic is_wr;
  logic pe_frame_ok;
  logic pe_locked;
  logic [4:0] dummy_dec;
  logic [7:0] status_word;

  // Pins come from the host's domain; reset to idle levels, no false edges
  pin_sync #(.W(4), .INIT(4'h5)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i({sck_i, ce_n_i, si_i, wp_n_i}),
    .level_o(pins_s)
  );
  assign sck_s = pins_s[3];
  assign ce_n_s = pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_d <= 1'b0;
      ce_n_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      ce_n_d <= ce_n_s;
    end
  end

  // RL20 - rising edge sampling
  assign sck_rise = sck_s & ~sck_d & ~ce_n_s;
  assign sck_fall = ~sck_s & sck_d & ~ce_n_s;
  assign ce_fall = ~ce_n_s & ce_n_d;
  assign ce_rise = ce_n_s & ~ce_n_d;
  assign next_opcode = {in_sr[6:0], si_s};

  // Dummy count of a read opcode, top bit marks a legal read
  function automatic logic [4:0] read_dummy(input logic [7:0] op, input logic qpi,
                                            input logic [3:0] sel);
    logic ok;
    logic [3:0] dflt;
    ok = 1'b1;
    dflt = DUMMY_SPI;
    case (op)
      // RL2 - same as fast read
      OP_FAST_READ, OP_FRDTR, OP_UNIQUE_ID, OP_DISC_PARAMS, OP_INFO_ROW: begin
        dflt = qpi ? DUMMY_QUAD : DUMMY_SPI;
      end
      OP_FRDO, OP_FRQO: begin
        ok = ~qpi;
      end
      OP_FRDIO: begin
        dflt = DUMMY_DUAL_IO;
        ok = ~qpi;
      end
      // RL5 - SPI only command
      OP_DUAL_IO_DDR_READ: begin
        dflt = DUMMY_DUAL_IO;
        ok = ~qpi;
      end
      OP_QUAD_IO_READ, OP_FRQDTR: begin
        dflt = DUMMY_QUAD;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    // RL1 - zero selects defaults
    read_dummy = {ok, (sel == 4'h0) ? dflt : sel};
  endfunction

  // Protected blocks counted down from the top of the array
  function automatic logic blk_locked(input logic [3:0] bp, input logic [BLK_W-1:0] blk);
    logic [BLK_W:0] span;
    span = '0;
    if (bp >= BP_ALL) begin
      span = {1'b1, {BLK_W{1'b0}}};
    end else if (bp != 4'h0) begin
      span = (BLK_W+1)'(1) << (bp - 4'h1);
    end
    blk_locked = (span != '0) && ({1'b0, blk} >= ({1'b1, {BLK_W{1'b0}}} - span));
  endfunction

  assign dummy_dec = read_dummy(next_opcode, qpi_mode_i, read_dummy_setting_i);

  // RL19 - opcode, body, end on rise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= PH_IDLE;
    end else if (ce_rise) begin
      phase <= PH_IDLE;
    end else if (ce_fall) begin
      phase <= (boot_armed && boot_enable_o) ? PH_BOOT : PH_OPCODE;
    end else if (sck_rise && phase == PH_OPCODE && bit_cnt == BITS_OPCODE - 6'h01) begin
      phase <= PH_BODY;
    end
  end

  // Counter saturates at 63, so program data longer than three bytes fails the byte-alignment check
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt <= '0;
    end else if (ce_fall) begin
      bit_cnt <= '0;
    end else if (sck_rise && bit_cnt != 6'h3F) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // RL20 - MSB first shifting
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_sr <= '0;
      opcode <= '0;
      addr_q <= '0;
    end else if (sck_rise) begin
      in_sr <= {in_sr[30:0], si_s};
      if (phase == PH_OPCODE && bit_cnt == BITS_OPCODE - 6'h01) begin
        opcode <= next_opcode;
      end
      if (phase == PH_BODY && bit_cnt == BITS_ADDR_END - 6'h01) begin
        addr_q <= {in_sr[22:0], si_s};
      end
    end
  end

  // Read decode for the datapath beyond this block
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dummy_cycles_o <= '0;
      read_cmd_valid_o <= 1'b0;
    end else if (ce_fall) begin
      dummy_cycles_o <= '0;
      read_cmd_valid_o <= 1'b0;
    end else if (sck_rise && phase == PH_OPCODE && bit_cnt == BITS_OPCODE - 6'h01) begin
      read_cmd_valid_o <= dummy_dec[4];
      dummy_cycles_o <= dummy_dec[3:0];
    end
  end

  assign exec = ce_rise && phase == PH_BODY;
  assign is_wr = opcode == OP_WRSR || opcode == OP_SET_EXT_PERSIST ||
                 opcode == OP_SET_EXT_WORK || opcode == OP_WR_BOOT;
  assign is_pe = opcode == OP_PP || opcode == OP_PPQ_A || opcode == OP_PPQ_B ||
                 opcode == OP_SER_A || opcode == OP_SER_B || opcode == OP_BER32 ||
                 opcode == OP_BER64 || opcode == OP_CER_A || opcode == OP_CER_B;

  // RL15 - disable bit with low pin
  assign sr_locked = status_write_disable_o & ~wp_n_s;

  // Write-enable frames carry the opcode only, longer ones are ignored
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (exec && bit_cnt == BITS_OPCODE && opcode == OP_WRITE_ENABLE) begin
      write_enable_latch_o <= 1'b1;
    end else if (exec && opcode == OP_WRDI) begin
      write_enable_latch_o <= 1'b0;
    // RL22 - latch drops after write
    end else if (exec && (is_wr || is_pe)) begin
      write_enable_latch_o <= 1'b0;
    end
  end

  // RL16 - needs the write latch
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_write_disable_o <= 1'b0;
      quad_enable_o <= 1'b0;
      block_protect_o <= BP_DEFAULT;
    end else if (exec && opcode == OP_WRSR && bit_cnt == BITS_ONE_BYTE &&
                 write_enable_latch_o && !sr_locked) begin
      // RL15 - locked bits stay
      status_write_disable_o <= in_sr[SR_WR_DISABLE_BIT];
      quad_enable_o <= in_sr[SR_QUAD_BIT];
      block_protect_o <= in_sr[SR_BP_MSB:SR_BP_LSB];
    end
  end

  // RL21 - working copy from persistent
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end

  // RL9 - persistent write also refreshes working copy
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_persist <= DS_DEFAULT;
    end else if (exec && opcode == OP_SET_EXT_PERSIST && bit_cnt == BITS_ONE_BYTE &&
                 write_enable_latch_o) begin
      ext_persist <= in_sr[7:EXT_DS_LSB];
    end
  end

  // RL6 - drive strength bits
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_strength_o <= DS_DEFAULT;
    end else if (load_pending) begin
      drive_strength_o <= ext_persist;
    end else if (exec && bit_cnt == BITS_ONE_BYTE && write_enable_latch_o &&
                 (opcode == OP_SET_EXT_WORK || opcode == OP_SET_EXT_PERSIST)) begin
      // RL8 - reserved codes kept as written
      drive_strength_o <= in_sr[7:EXT_DS_LSB];
    end
  end

  // RL10 - aligned start address
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_addr <= BOOT_ADDR_DEFAULT;
      boot_dly <= BOOT_DLY_DEFAULT;
      boot_enable_o <= 1'b0;
    end else if (exec && opcode == OP_WR_BOOT && bit_cnt == BITS_BOOT_WORD &&
                 write_enable_latch_o) begin
      // RL11 - top byte discarded
      boot_addr <= in_sr[BOOT_ADDR_MSB:BOOT_ADDR_LSB];
      // RL12 - start delay field
      boot_dly <= in_sr[BOOT_DLY_MSB:BOOT_DLY_LSB];
      // RL14 - boot enable bit
      boot_enable_o <= in_sr[BOOT_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_start_address_o <= '0;
      boot_delay_cycles_o <= DUMMY_SPI;
    end else begin
      boot_start_address_o <= {boot_addr, 5'h00};
      // RL13 - zero means default
      if (boot_dly == 4'h0) begin
        boot_delay_cycles_o <= quad_enable_o ? DUMMY_QUAD : DUMMY_SPI;
      end else begin
        boot_delay_cycles_o <= boot_dly;
      end
    end
  end

  // Boot arms only for the first frame after reset, while boot_enable_o is still clear from reset, so boot never streams
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_armed <= 1'b1;
    end else if (ce_fall) begin
      boot_armed <= 1'b0;
    end
  end

  // RL14 - delay then boot data
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_cnt <= '0;
      boot_data_start_o <= 1'b0;
    end else begin
      boot_data_start_o <= 1'b0;
      if (ce_fall) begin
        boot_cnt <= '0;
      end else if (phase == PH_BOOT && sck_rise && boot_cnt != 4'hF) begin
        boot_cnt <= boot_cnt + 4'h1;
        if (boot_cnt + 4'h1 == boot_delay_cycles_o) begin
          boot_data_start_o <= 1'b1;
        end
      end
    end
  end

  // RL18 - block protect region check
  assign pe_locked = (opcode == OP_CER_A || opcode == OP_CER_B) ? (block_protect_o != 4'h0) :
                     blk_locked(block_protect_o, addr_q[BLK_LSB+BLK_W-1:BLK_LSB]);

  always_comb begin
    pe_frame_ok = 1'b0;
    case (opcode)
      OP_CER_A, OP_CER_B: begin
        pe_frame_ok = bit_cnt == BITS_OPCODE;
      end
      OP_PP, OP_PPQ_A, OP_PPQ_B: begin
        pe_frame_ok = bit_cnt > BITS_ADDR_END && bit_cnt[2:0] == 3'h0;
      end
      default: begin
        pe_frame_ok = bit_cnt == BITS_ADDR_END;
      end
    endcase
  end

  // RL16 - program or erase gating
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pe_start_o <= 1'b0;
      pe_refused_o <= 1'b0;
      pe_address_o <= '0;
    end else begin
      pe_start_o <= 1'b0;
      pe_refused_o <= 1'b0;
      if (exec && is_pe) begin
        pe_address_o <= addr_q;
        if (write_enable_latch_o && pe_frame_ok && !pe_locked) begin
          pe_start_o <= 1'b1;
        end else begin
          pe_refused_o <= 1'b1;
        end
      end
    end
  end

  // Status image, lowest bit unused
  assign status_word = {status_write_disable_o, quad_enable_o, block_protect_o,
                        write_enable_latch_o, 1'b0};

  // Read data changes on falling edges so it is stable at the host's rise
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_sr <= '0;
      out_act <= 1'b0;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (ce_n_s) begin
      out_act <= 1'b0;
      so_oe_o <= 1'b0;
    end else if (sck_rise && phase == PH_OPCODE && bit_cnt == BITS_OPCODE - 6'h01) begin
      case (next_opcode)
        OP_RDSR: begin
          out_sr <= {status_word, 24'h0};
          out_act <= 1'b1;
        end
        OP_RD_EXT: begin
          // RL7 - reserved bits read one
          out_sr <= {drive_strength_o, EXT_RESERVED, 24'h0};
          out_act <= 1'b1;
        end
        OP_RD_BOOT: begin
          out_sr <= {BOOT_RESERVED, boot_addr, boot_dly, boot_enable_o};
          out_act <= 1'b1;
        end
        default: begin
          out_act <= 1'b0;
        end
      endcase
    end else if (sck_fall && out_act) begin
      so_o <= out_sr[31];
      so_oe_o <= 1'b1;
      out_sr <= {out_sr[30:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// file: common/flash_cfg_pkg.sv
// Constants for the flash read configuration and write-protect block
// Functional notes
// RL1 - Default dummy counts: 8, 6 or 4
// RL2 - Unique-ID, SFDP, info-row use fast-read dummy
// RL3 - Host sets enough dummy for mode byte
// RL4 - Host avoids I/O contention during mode byte
// RL5 - Dual I/O DTR read refused in QPI
// RL6 - Extended bits 7:5 select drive strength
// RL7 - Extended bits 4:0 reserved, read as one
// RL8 - Drive code 111 default, 000/100 reserved
// RL9 - Persistent and working extended-read writes
// RL10 - Boot bits 23:5 hold aligned start address
// RL11 - Boot bits 31:24 reserved, zero
// RL12 - Boot bits 4:1 set start delay
// RL13 - Zero delay means 8, or 6 with quad
// RL14 - Boot bit 0 enables boot output (code sets boot_enable_o from it, but boot never streams)
// RL15 - Disable bit plus low pin locks status
// RL16 - Writes ignored while write latch clear
// RL17 - Host sets write latch before writes
// RL18 - Block-protect bits lock array regions
// RL19 - Opcode byte first, frame ends on rise
// RL20 - MSB first, sampled on rising edges
// RL21 - Working extended copy loaded at power-up
// RL22 - Write latch cleared after each write
`default_nettype none
package flash_cfg_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_FRDTR = 8'h0D;
  localparam logic [7:0] OP_FRDO = 8'h3B;
  localparam logic [7:0] OP_FRQO = 8'h6B;
  localparam logic [7:0] OP_FRDIO = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_DDR_READ = 8'hBD;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_FRQDTR = 8'hED;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
  localparam logic [7:0] OP_DISC_PARAMS = 8'h5A;
  localparam logic [7:0] OP_INFO_ROW = 8'h68;
  localparam logic [7:0] OP_SET_EXT_PERSIST = 8'h85;
  localparam logic [7:0] OP_SET_EXT_WORK = 8'h83;
  localparam logic [7:0] OP_RD_EXT = 8'h81;
  localparam logic [7:0] OP_WR_BOOT = 8'h15;
  localparam logic [7:0] OP_RD_BOOT = 8'h14;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PPQ_A = 8'h32;
  localparam logic [7:0] OP_PPQ_B = 8'h38;
  localparam logic [7:0] OP_SER_A = 8'hD7;
  localparam logic [7:0] OP_SER_B = 8'h20;
  localparam logic [7:0] OP_BER32 = 8'h52;
  localparam logic [7:0] OP_BER64 = 8'hD8;
  localparam logic [7:0] OP_CER_A = 8'hC7;
  localparam logic [7:0] OP_CER_B = 8'h60;
  // Frame bit counts
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ONE_BYTE = 6'h10;
  localparam logic [5:0] BITS_ADDR_END = 6'h20;
  localparam logic [5:0] BITS_BOOT_WORD = 6'h28;
  // Default dummy counts
  localparam logic [3:0] DUMMY_SPI = 4'h8;
  localparam logic [3:0] DUMMY_QUAD = 4'h6;
  localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
  // Extended read register
  localparam int DS_W = 3;
  localparam int EXT_DS_LSB = 5;
  localparam logic [2:0] DS_DEFAULT = 3'h7;
  localparam logic [4:0] EXT_RESERVED = 5'h1F;
  // Boot register fields
  localparam int BOOT_ADDR_MSB = 23;
  localparam int BOOT_ADDR_LSB = 5;
  localparam int BOOT_DLY_MSB = 4;
  localparam int BOOT_DLY_LSB = 1;
  localparam int BOOT_EN_BIT = 0;
  localparam logic [18:0] BOOT_ADDR_DEFAULT = 19'h00000;
  localparam logic [3:0] BOOT_DLY_DEFAULT = 4'h0;
  localparam logic [7:0] BOOT_RESERVED = 8'h00;
  // Status register fields
  localparam int SR_WR_DISABLE_BIT = 7;
  localparam int SR_QUAD_BIT = 6;
  localparam int SR_BP_MSB = 5;
  localparam int SR_BP_LSB = 2;
  localparam int SR_LATCH_BIT = 1;
  localparam logic [3:0] BP_DEFAULT = 4'h0;
  // Array geometry: 64 KB blocks
  localparam int BLK_LSB = 16;
  localparam int BLK_W = 5;
  localparam logic [3:0] BP_ALL = 4'h6;
endpackage
`default_nettype wire

// file: hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Only stages two and three are compared, per bit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= INIT;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level_o[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/flash_cfg_asserts.sv
// Assertion checker for the flash configuration and protect block
`timescale 1ns/1ps
`default_nettype none
module flash_cfg_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_n_i,
  input wire logic wp_n_i,
  input wire logic so_oe_o,
  input wire logic [flash_cfg_pkg::DS_W-1:0] drive_strength_o,
  input wire logic [23:0] boot_start_address_o,
  input wire logic [3:0] boot_delay_cycles_o,
  input wire logic quad_enable_o,
  input wire logic status_write_disable_o,
  input wire logic [3:0] block_protect_o,
  input wire logic write_enable_latch_o,
  input wire logic pe_start_o,
  input wire logic pe_refused_o
);
  import flash_cfg_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Eight cycles cover the pin synchroniser latency
  sequence wp_locked;
    (status_write_disable_o && !wp_n_i)[*8];
  endsequence
  sequence ce_idle;
    ce_n_i[*8];
  endsequence
  a_drive_reset_default: assert property ($fell(rst_i) |-> drive_strength_o == 3'h7)
    else $error("drive strength not default after reset");
  a_pe_needs_latch: assert property (pe_start_o |-> $past(write_enable_latch_o))
    else $error("program or erase started without latch");
  a_latch_cleared: assert property ((pe_start_o || pe_refused_o) |-> ##[0:1] !write_enable_latch_o)
    else $error("latch kept after program or erase");
  a_status_locked: assert property (wp_locked |=> $stable({status_write_disable_o, quad_enable_o, block_protect_o}))
    else $error("status bits changed while pin locked");
  a_status_latch: assert property ($changed({quad_enable_o, status_write_disable_o, block_protect_o})
    |-> $past(write_enable_latch_o))
    else $error("status bits changed without latch");
  a_drive_latch: assert property ($changed(drive_strength_o) |-> $past(write_enable_latch_o))
    else $error("drive strength changed without latch");
  a_boot_delay_nonzero: assert property (boot_delay_cycles_o != 4'h0)
    else $error("boot delay of zero cycles");
  a_boot_addr_aligned: assert property (boot_start_address_o[4:0] == 5'h00)
    else $error("boot address not on a 32 byte boundary");
  a_so_released: assert property (ce_idle |-> !so_oe_o)
    else $error("data out driven outside a frame");
  a_pe_all_protect: assert property (pe_start_o |-> block_protect_o < 4'h6)
    else $error("erase started with whole array protected");
  a_pe_single_pulse: assert property (pe_start_o |-> !pe_refused_o ##1 !pe_start_o)
    else $error("start pulse longer than one cycle");
endmodule
`default_nettype wire

// file: sim/spi_host_model.sv
// Behavioural serial host, mode 0, single data line
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic sck_o,
  output logic ce_n_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    sck_o = 1'b0;
    ce_n_o = 1'b1;
    si_o = 1'b0;
  end
  // no mode-byte reads, so never driven
  task automatic frame(input logic [39:0] tx, input int n, input bit hold, output logic [39:0] rx);
    rx = '0;
    ce_n_o = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = tx[i];
      #100 sck_o = 1'b1;
      // Sampled late: the device answers after its synchroniser
      #100 rx = {rx[38:0], so_i};
      sck_o = 1'b0;
    end
    if (!hold) begin
      end_frame();
    end
  endtask
  // Clock stands still; released line shows no stale value
  task automatic end_frame();
    #100 ce_n_o = 1'b1;
    si_o = ~si_o;
    #400;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the flash configuration and protect block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_cfg_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic qpi_mode_i = 1'b0;
  logic [3:0] read_dummy_setting_i = 4'h0;
  logic sck_i, ce_n_i, si_i, so_o, so_oe_o, read_cmd_valid_o, boot_enable_o, boot_data_start_o;
  logic quad_enable_o, status_write_disable_o, write_enable_latch_o, pe_start_o, pe_refused_o;
  logic [DS_W-1:0] drive_strength_o;
  logic [3:0] dummy_cycles_o, boot_delay_cycles_o, block_protect_o;
  logic [23:0] boot_start_address_o, pe_address_o;
  logic [39:0] rx;
  localparam logic [103:0] OPS = {OP_FAST_READ, OP_FRDTR, OP_FRDO, OP_FRQO, OP_FRDIO, OP_DUAL_IO_DDR_READ,
    OP_QUAD_IO_READ, OP_FRQDTR, OP_UNIQUE_ID, OP_DISC_PARAMS, OP_INFO_ROW, OP_FAST_READ, OP_DUAL_IO_DDR_READ};
  localparam logic [51:0] DUM = 52'h8888446688860;
  int fails = 0;
  int total_checks = 0;
  int starts = 0;
  int refusals = 0;
  int boots = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  flash_cfg_protect uut (.ref_clk_i, .rst_i, .sck_i, .ce_n_i, .si_i, .wp_n_i, .qpi_mode_i,
    .read_dummy_setting_i, .so_o, .so_oe_o, .drive_strength_o, .dummy_cycles_o, .read_cmd_valid_o,
    .boot_start_address_o, .boot_delay_cycles_o, .boot_enable_o, .boot_data_start_o, .quad_enable_o,
    .status_write_disable_o, .block_protect_o, .write_enable_latch_o, .pe_start_o, .pe_refused_o,
    .pe_address_o);
  spi_host_model host (.sck_o(sck_i), .ce_n_o(ce_n_i), .si_o(si_i), .so_i(so_o));
  always @(posedge ref_clk_i) begin
    if (pe_start_o === 1'b1) starts++;
    if (pe_refused_o === 1'b1) refusals++;
    if (boot_data_start_o === 1'b1) boots++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge ref_clk_i);
    #2;
  endtask
  task automatic cmd(input logic [39:0] tx, input int n);
    host.frame(tx, n, 1'b0, rx);
    settle();
  endtask
  task automatic wcmd(input logic [39:0] tx, input int n);
    cmd({32'h0, OP_WRITE_ENABLE}, 8);
    cmd(tx, n);
  endtask
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    #2 rst_i = 1'b0;
    settle();
    check(32'(drive_strength_o), 32'h7);
    check(32'(boot_delay_cycles_o), 32'h8);
    check({7'h0, boot_enable_o, boot_start_address_o}, 32'h0);
    cmd({24'h0, OP_RD_EXT, 8'h00}, 16);
    check(32'(rx[7:0]), 32'hFF);
    cmd({OP_RD_BOOT, 32'h0}, 40);
    check(rx[31:0], 32'h0);
    // Write without latch is dropped
    cmd({24'h0, OP_SET_EXT_WORK, 8'h20}, 16);
    check(32'(drive_strength_o), 32'h7);
    wcmd({32'h0, OP_WRDI}, 8);
    check(32'(write_enable_latch_o), 32'h0);
    cmd({32'h0, OP_WRITE_ENABLE}, 8);
    check(32'(write_enable_latch_o), 32'h1);
    cmd({24'h0, OP_SET_EXT_PERSIST, 8'h20}, 16);
    check(32'(drive_strength_o), 32'h1);
    check(32'(write_enable_latch_o), 32'h0);
    cmd({24'h0, OP_RD_EXT, 8'h00}, 16);
    check(32'(rx[7:0]), 32'h3F);
    // Every drive code, reserved ones kept as written
    for (int c = 0; c < 8; c++) begin
      wcmd({24'h0, OP_SET_EXT_WORK, 3'(c), 5'h00}, 16);
      check(32'(drive_strength_o), 32'(c));
    end
    // Dummy count per read opcode, last two in QPI
    for (int i = 0; i < 13; i++) begin
      qpi_mode_i = (i > 10);
      host.frame({32'h0, OPS[8*(12-i)+:8]}, 8, 1'b1, rx);
      settle();
      check(32'(read_cmd_valid_o), 32'(i != 12));
      if (i != 12) check(32'(dummy_cycles_o), 32'(DUM[4*(12-i)+:4]));
      host.end_frame();
    end
    qpi_mode_i = 1'b0;
    read_dummy_setting_i = 4'h5;
    host.frame({32'h0, OP_UNIQUE_ID}, 8, 1'b1, rx);
    settle();
    check(32'(dummy_cycles_o), 32'h5);
    host.end_frame();
    read_dummy_setting_i = 4'h0;
    wcmd({24'h0, OP_WRSR, 8'hCC}, 16);
    check(32'({status_write_disable_o, quad_enable_o, block_protect_o}), 32'h33);
    check(32'(boot_delay_cycles_o), 32'h6);
    cmd({24'h0, OP_RDSR, 8'h00}, 16);
    check(32'(rx[7:0]), 32'hCC);
    wcmd({OP_WR_BOOT, 32'h0001_2345}, 40);
    check({3'h0, boot_enable_o, boot_delay_cycles_o, boot_start_address_o}, 32'h1201_2340);
    cmd({OP_RD_BOOT, 32'h0}, 40);
    check(rx[31:0], 32'h0001_2345);
    // Top four of 32 blocks protected: boundary either side
    cmd({8'h0, OP_BER64, 24'h00_0000}, 32);
    check(32'(starts), 32'h0);
    check(32'(refusals), 32'h1);
    wcmd({8'h0, OP_SER_B, 24'h1C_0000}, 32);
    check(32'(refusals), 32'h2);
    wcmd({8'h0, OP_BER64, 24'h1B_FF00}, 32);
    check(32'(starts), 32'h1);
    check(32'(pe_address_o), 32'h1B_FF00);
    wcmd({32'h0, OP_CER_A}, 8);
    check(32'(refusals), 32'h3);
    check(32'(write_enable_latch_o), 32'h0);
    // Pin low with disable bit set locks status
    wp_n_i = 1'b0;
    wcmd({24'h0, OP_WRSR, 8'h00}, 16);
    check(32'({status_write_disable_o, quad_enable_o, block_protect_o}), 32'h33);
    check(32'(write_enable_latch_o), 32'h0);
    wp_n_i = 1'b1;
    settle();
    wcmd({24'h0, OP_WRSR, 8'h00}, 16);
    check(32'({status_write_disable_o, quad_enable_o, block_protect_o}), 32'h0);
    check(32'(boots), 32'h0);
    end_of_test();
  end
endmodule
bind flash_cfg_protect flash_cfg_asserts chk (.ref_clk_i, .rst_i, .ce_n_i, .wp_n_i, .so_oe_o,
  .drive_strength_o, .boot_start_address_o, .boot_delay_cycles_o, .quad_enable_o, .status_write_disable_o,
  .block_protect_o, .write_enable_latch_o, .pe_start_o, .pe_refused_o);
`default_nettype wire
